// File: src/fsw_defines.svh
// constants shared by both ends of the status and write-enable link
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH

// instruction codes
`define FSW_OP_WREN      8'h06
`define FSW_OP_VWREN     8'h50
`define FSW_OP_WRDIS     8'h04
`define FSW_OP_RDST_LO   8'h05
`define FSW_OP_RDST_HI   8'h35
`define FSW_OP_WRST      8'h01
`define FSW_OP_PROG      8'h02
`define FSW_OP_QPROG     8'h32
`define FSW_OP_ERASE4K   8'h20
`define FSW_OP_ERASE32K  8'h52
`define FSW_OP_ERASE64K  8'hD8
`define FSW_OP_ERASE_A   8'hC7
`define FSW_OP_ERASE_B   8'h60
`define FSW_OP_RDID      8'hAB
`define FSW_OP_SREG_ERS  8'h44
`define FSW_OP_SREG_PGM  8'h42
`define FSW_OP_SREG_RD   8'h48

// status_low layout
`define FSW_ST_BUSY      0
`define FSW_ST_WPL       1
`define FSW_LO_WMASK     8'hFC
// status_high layout
`define FSW_HI_SPROT2    0
`define FSW_HI_QIO       1
`define FSW_HI_LOCK1     3
`define FSW_HI_COMP      6
`define FSW_HI_WMASK     8'h7F
`define FSW_HI_LOCKS     8'h38
`define FSW_HI_8BIT_CLR  8'h42
`define FSW_STATUS_RST   8'h00

// byte counts of instructions
`define FSW_BYTES_ONE    3'd1
`define FSW_BYTES_WR8    3'd2
`define FSW_BYTES_WR16   3'd3
`define FSW_BYTES_ADDR   3'd4
`define FSW_ID_LAST_DUMMY 3'd3
`define FSW_BYTE_MAX     3'd7
`define FSW_BIT_LAST     3'd7

// security register address decode
`define FSW_SREG_UPPER   8'h00
`define FSW_SREG_MID1    8'h10
`define FSW_SREG_MID2    8'h20
`define FSW_SREG_MID3    8'h30

// self-timed write cycle
`define FSW_CLK_MHZ      50
`define FSW_TW_US        10
`define FSW_TW_CYC       (`FSW_TW_US * `FSW_CLK_MHZ)

// host register map and link divider
`define FSW_REG_TXDATA   4'h0
`define FSW_REG_CTRL     4'h4
`define FSW_REG_STATUS   4'h8
`define FSW_REG_RXDATA   4'hC
`define FSW_CTRL_TXN_LSB 0
`define FSW_CTRL_RXN_LSB 8
`define FSW_HOST_HALF    4'd8

`endif

// File: src/fsw_pkg.sv
// types shared by both ends of the link
package fsw_pkg;
    typedef logic [7:0] fsw_byte_t;
    typedef enum logic [2:0] {
        FSW_H_IDLE,
        FSW_H_SETUP,
        FSW_H_HIGH,
        FSW_H_LOW,
        FSW_H_LAST,
        FSW_H_GAP
    } fsw_host_state_e;
endpackage

// File: src/fsw_link_if.sv
// serial link between the host controller and the flash status logic
`timescale 1ns/100ps
interface fsw_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic miso_line;

    // line floats high while the device does not drive it
    assign miso_line = miso_oe_n ? 1'b1 : miso;

    modport device (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso,
        output miso_oe_n
    );
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input  miso_line
    );
endinterface

// File: src/fsw_device.sv
// flash device end: write-enable latch, status registers, id and security decode
//
// Behaviour
// - write enable opcode sets write permission latch
// - host enables writes before every modifying instruction
// - host frames write enable with chip select
// - volatile enable arms status write, latch untouched
// - host sends volatile enable before status write
// - write disable clears write permission latch
// - latch clears at power-up and op completion
// - write disable cancels pending volatile enable
// - two status read opcodes, msb first out
// - status reads accepted even while busy
// - status byte repeats until chip select rises
// - status write changes only bits 7-2, 14-8
// - security lock bits never return to zero; a lock set only by a volatile status write clears on power cycle
// - non-volatile status write needs latch set
// - volatile write keeps latch, protect2, locks
// - power-on reloads status from non-volatile copy
// - id byte after three dummies, repeating
// - security register decode from address bytes
// - status write ends after 8 or 16 bits
// - busy high during self-timed status write
// - volatile status update keeps busy low
// - writes not ending on byte boundary ignored
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "fsw_defines.svh"
module fsw_device
    import fsw_pkg::*;
#(
    // arbitrary identification value
    parameter fsw_byte_t DEVICE_ID = 8'h5A
) (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // power cycle of the storage cell
    input  wire logic        power_cycle_i,
    // link
    fsw_link_if.device       link,
    // status view
    output logic             busy_o,
    output fsw_byte_t        status_low_o,
    output fsw_byte_t        status_high_o,
    // accepted array or security operation
    output logic             op_start_o,
    output fsw_byte_t        op_code_o,
    output logic [23:0]      op_addr_o,
    output logic [1:0]       sreg_sel_o
);
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [1:0]  mosi_s;
    logic [2:0]  bit_cnt_r;
    logic [2:0]  byte_cnt_r;
    logic [6:0]  shift_r;
    fsw_byte_t   op_r;
    logic [23:0] addr_r;
    fsw_byte_t   d1_r;
    fsw_byte_t   d2_r;
    logic        busy_at_op_r;
    fsw_byte_t   tx_r;
    logic        tx_act_r;
    logic        miso_r;
    logic        miso_oe_n_r;
    fsw_byte_t   vol_low_r;
    fsw_byte_t   vol_high_r;
    fsw_byte_t   nv_low_r;
    fsw_byte_t   nv_high_r;
    logic        wpl_r;
    logic        varm_r;
    logic        busy_r;
    logic [15:0] tw_cnt_r;
    logic        op_start_r;
    logic [1:0]  sreg_sel_r;

    // edge detection reads only the second and third stages
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_s <= 3'h0;
            cs_s   <= 3'h7;
            mosi_s <= 2'h0;
        end
        else if (ce_i)
        begin
            sclk_s <= {sclk_s[1:0], link.sclk};
            cs_s   <= {cs_s[1:0], link.cs_n};
            mosi_s <= {mosi_s[0], link.mosi};
        end
    end

    wire       cs_low    = ~cs_s[1];
    wire       cs_rise   = cs_s[1] & ~cs_s[2];
    wire       sclk_rise = sclk_s[1] & ~sclk_s[2] & cs_low;
    wire       sclk_fall = ~sclk_s[1] & sclk_s[2] & cs_low;
    wire       byte_done = sclk_rise & (bit_cnt_r == `FSW_BIT_LAST);
    fsw_byte_t new_byte;
    fsw_byte_t op_now;
    fsw_byte_t st_low;
    fsw_byte_t st_high;
    assign new_byte = {shift_r, mosi_s[1]};
    assign op_now   = (byte_cnt_r == 3'd0) ? new_byte : op_r;
    assign st_low   = {vol_low_r[7:2], wpl_r, busy_r};
    // suspend flag reads zero: suspend is not part of this block
    assign st_high  = vol_high_r & `FSW_HI_WMASK;

    // instruction receive: opcode bits taken on rising link clock
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bit_cnt_r    <= 3'd0;
            byte_cnt_r   <= 3'd0;
            shift_r      <= 7'h00;
            op_r         <= 8'h00;
            addr_r       <= 24'h00_0000;
            d1_r         <= 8'h00;
            d2_r         <= 8'h00;
            busy_at_op_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!cs_low)
            begin
                bit_cnt_r  <= 3'd0;
                byte_cnt_r <= 3'd0;
            end
            else if (sclk_rise)
            begin
                bit_cnt_r <= bit_cnt_r + 3'd1;
                shift_r   <= new_byte[6:0];
                if (byte_done)
                begin
                    if (byte_cnt_r != `FSW_BYTE_MAX)
                        byte_cnt_r <= byte_cnt_r + 3'd1;
                    if (byte_cnt_r == 3'd0)
                    begin
                        op_r         <= new_byte;
                        busy_at_op_r <= busy_r;
                    end
                    if (byte_cnt_r == 3'd1)
                        d1_r <= new_byte;
                    if (byte_cnt_r == 3'd2)
                        d2_r <= new_byte;
                    if (byte_cnt_r != 3'd0 && byte_cnt_r < `FSW_BYTES_ADDR)
                        addr_r <= {addr_r[15:0], new_byte};
                end
            end
        end
    end

    // output shifter: bits leave on falling link clock, msb first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_r        <= 8'h00;
            tx_act_r    <= 1'b0;
            miso_r      <= 1'b0;
            miso_oe_n_r <= 1'b1;
        end
        else if (ce_i)
        begin
            if (!cs_low)
            begin
                tx_act_r    <= 1'b0;
                miso_oe_n_r <= 1'b1;
            end
            else if (byte_done)
            begin
                // reloaded every byte so a polling read sees busy fall
                if (op_now == `FSW_OP_RDST_LO)
                begin
                    tx_r     <= st_low;
                    tx_act_r <= 1'b1;
                end
                else if (op_now == `FSW_OP_RDST_HI)
                begin
                    tx_r     <= st_high;
                    tx_act_r <= 1'b1;
                end
                else if (op_now == `FSW_OP_RDID && !busy_at_op_r
                         && byte_cnt_r >= `FSW_ID_LAST_DUMMY)
                begin
                    tx_r     <= DEVICE_ID;
                    tx_act_r <= 1'b1;
                end
            end
            else if (sclk_fall && tx_act_r)
            begin
                miso_r      <= tx_r[7];
                tx_r        <= {tx_r[6:0], 1'b0};
                miso_oe_n_r <= 1'b0;
            end
        end
    end

    // commit on chip select rise
    wire aligned  = (bit_cnt_r == 3'd0);
    wire may_run  = aligned & ~busy_at_op_r & ~busy_r;
    wire wr_len   = (byte_cnt_r == `FSW_BYTES_WR8) | (byte_cnt_r == `FSW_BYTES_WR16);
    wire has_addr = byte_cnt_r >= `FSW_BYTES_ADDR;
    wire array_op = (op_r == `FSW_OP_PROG || op_r == `FSW_OP_QPROG
                     || op_r == `FSW_OP_ERASE4K || op_r == `FSW_OP_ERASE32K
                     || op_r == `FSW_OP_ERASE64K) ? has_addr
                  : (op_r == `FSW_OP_ERASE_A || op_r == `FSW_OP_ERASE_B);
    wire sreg_op  = (op_r == `FSW_OP_SREG_ERS || op_r == `FSW_OP_SREG_PGM) & has_addr;
    logic [1:0] sel;
    always_comb
    begin
        sel = 2'd0;
        if (addr_r[23:16] == `FSW_SREG_UPPER)
        begin
            case (addr_r[15:8])
                `FSW_SREG_MID1: sel = 2'd1;
                `FSW_SREG_MID2: sel = 2'd2;
                `FSW_SREG_MID3: sel = 2'd3;
                default:        sel = 2'd0;
            endcase
        end
    end
    wire sreg_locked = vol_high_r[`FSW_HI_LOCK1 + {1'b0, sel} - 4'd1];
    wire sreg_ok     = sreg_op & (sel != 2'd0) & ~sreg_locked;

    // new status values for a status write
    fsw_byte_t wr_low;
    fsw_byte_t wr_high;
    always_comb
    begin
        wr_low  = (d1_r & `FSW_LO_WMASK) | (vol_low_r & ~`FSW_LO_WMASK);
        wr_high = (byte_cnt_r == `FSW_BYTES_WR16) ? d2_r
                : (vol_high_r & ~`FSW_HI_8BIT_CLR);
        wr_high = (wr_high | (vol_high_r & `FSW_HI_LOCKS)) & `FSW_HI_WMASK;
        if (varm_r)
            wr_high[`FSW_HI_SPROT2] = wr_high[`FSW_HI_SPROT2]
                                     | vol_high_r[`FSW_HI_SPROT2];
    end

    // status state, latch and self-timed cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            nv_low_r   <= `FSW_STATUS_RST;
            nv_high_r  <= `FSW_STATUS_RST;
            vol_low_r  <= `FSW_STATUS_RST;
            vol_high_r <= `FSW_STATUS_RST;
            wpl_r      <= 1'b0;
            varm_r     <= 1'b0;
            busy_r     <= 1'b0;
            tw_cnt_r   <= 16'h0000;
            op_start_r <= 1'b0;
            sreg_sel_r <= 2'd0;
        end
        else if (ce_i)
        begin
            op_start_r <= 1'b0;
            if (power_cycle_i)
            begin
                vol_low_r  <= nv_low_r;
                vol_high_r <= nv_high_r;
                wpl_r      <= 1'b0;
                varm_r     <= 1'b0;
                busy_r     <= 1'b0;
            end
            else if (busy_r)
            begin
                if (tw_cnt_r == 16'h0001)
                begin
                    busy_r <= 1'b0;
                    wpl_r  <= 1'b0;
                end
                tw_cnt_r <= tw_cnt_r - 16'h0001;
            end
            else if (cs_rise && may_run && byte_cnt_r != 3'd0)
            begin
                case (op_r)
                    `FSW_OP_WREN:  wpl_r <= 1'b1;
                    `FSW_OP_VWREN: varm_r <= 1'b1;
                    `FSW_OP_WRDIS:
                    begin
                        wpl_r  <= 1'b0;
                        varm_r <= 1'b0;
                    end
                    `FSW_OP_WRST:
                    begin
                        if (wr_len && varm_r)
                        begin
                            // busy stays low, latch untouched
                            vol_low_r  <= wr_low;
                            vol_high_r <= wr_high;
                            varm_r     <= 1'b0;
                        end
                        else if (wr_len && wpl_r)
                        begin
                            vol_low_r  <= wr_low;
                            vol_high_r <= wr_high;
                            nv_low_r   <= wr_low;
                            nv_high_r  <= wr_high;
                            busy_r     <= 1'b1;
                            tw_cnt_r   <= 16'(`FSW_TW_CYC);
                        end
                    end
                    default:
                    begin
                        if ((array_op || sreg_ok) && wpl_r)
                        begin
                            op_start_r <= 1'b1;
                            sreg_sel_r <= sreg_op ? sel : 2'd0;
                            busy_r     <= 1'b1;
                            tw_cnt_r   <= 16'(`FSW_TW_CYC);
                        end
                    end
                endcase
            end
        end
    end

    assign link.miso      = miso_r;
    assign link.miso_oe_n = miso_oe_n_r;
    assign busy_o         = busy_r;
    assign status_low_o   = {vol_low_r[7:2], wpl_r, busy_r};
    assign status_high_o  = vol_high_r;
    assign op_start_o     = op_start_r;
    assign op_code_o      = op_r;
    assign op_addr_o      = addr_r;
    assign sreg_sel_o     = sreg_sel_r;
endmodule // fsw_device

// File: src/fsw_host.sv
// host end: register-driven serial master for the flash status logic
`timescale 1ns/100ps
`include "fsw_defines.svh"
module fsw_host
    import fsw_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // link
    fsw_link_if.host         link
);
    fsw_host_state_e state_r;
    logic [31:0] tx_r;
    logic [31:0] sout_r;
    logic [31:0] rx_r;
    logic [31:0] rdata_r;
    logic [6:0]  bits_r;
    logic [3:0]  div_r;
    logic        sclk_r;
    logic        cs_n_r;
    logic        mosi_r;
    logic [1:0]  miso_s;

    wire        idle     = (state_r == FSW_H_IDLE);
    wire        half     = (div_r == `FSW_HOST_HALF - 4'd1);
    wire [2:0]  txn      = wdata_i[`FSW_CTRL_TXN_LSB +: 3];
    wire [2:0]  rxn      = wdata_i[`FSW_CTRL_RXN_LSB +: 3];
    wire [6:0]  nbits    = {1'b0, txn + rxn, 3'b000};
    wire        start    = wr_i && addr_i == `FSW_REG_CTRL && idle && nbits != 7'd0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            miso_s <= 2'b11;
        else if (ce_i)
            miso_s <= {miso_s[0], link.miso_line};
    end

    // register writes; transfer requests are refused while one runs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_r <= 32'h0000_0000;
        else if (ce_i && wr_i && addr_i == `FSW_REG_TXDATA && idle)
            tx_r <= wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_r <= 32'h0000_0000;
        else if (ce_i)
        begin
            rdata_r <= 32'h0000_0000;
            if (rd_i)
            begin
                case (addr_i)
                    `FSW_REG_TXDATA: rdata_r <= tx_r;
                    `FSW_REG_STATUS: rdata_r <= {31'h0000_0000, ~idle};
                    `FSW_REG_RXDATA: rdata_r <= rx_r;
                    default:         rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // link clock from a divider; mode 0, bits sampled on rising edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= FSW_H_IDLE;
            sout_r  <= 32'h0000_0000;
            rx_r    <= 32'h0000_0000;
            bits_r  <= 7'd0;
            div_r   <= 4'd0;
            sclk_r  <= 1'b0;
            cs_n_r  <= 1'b1;
            mosi_r  <= 1'b0;
        end
        else if (ce_i)
        begin
            div_r <= (idle || half) ? 4'd0 : div_r + 4'd1;
            case (state_r)
                FSW_H_IDLE:
                begin
                    if (start)
                    begin
                        sout_r  <= tx_r;
                        bits_r  <= nbits;
                        cs_n_r  <= 1'b0;
                        mosi_r  <= tx_r[31];
                        state_r <= FSW_H_SETUP;
                    end
                end
                FSW_H_SETUP, FSW_H_LOW:
                begin
                    if (half)
                    begin
                        sclk_r  <= 1'b1;
                        rx_r    <= {rx_r[30:0], miso_s[1]};
                        bits_r  <= bits_r - 7'd1;
                        state_r <= FSW_H_HIGH;
                    end
                end
                FSW_H_HIGH:
                begin
                    if (half)
                    begin
                        sclk_r <= 1'b0;
                        if (bits_r == 7'd0)
                            state_r <= FSW_H_LAST;
                        else
                        begin
                            sout_r  <= {sout_r[30:0], 1'b0};
                            mosi_r  <= sout_r[30];
                            state_r <= FSW_H_LOW;
                        end
                    end
                end
                FSW_H_LAST:
                begin
                    // whole bytes only, so write instructions are not dropped
                    if (half)
                    begin
                        cs_n_r  <= 1'b1;
                        state_r <= FSW_H_GAP;
                    end
                end
                FSW_H_GAP:
                begin
                    if (half)
                        state_r <= FSW_H_IDLE;
                end
                default: state_r <= FSW_H_IDLE;
            endcase
        end
    end

    assign rdata_o   = rdata_r;
    assign link.sclk = sclk_r;
    assign link.cs_n = cs_n_r;
    assign link.mosi = mosi_r;
endmodule // fsw_host

// File: tb/fsw_monitor.sv
// timing checks on the serial link between host and device
`timescale 1ns/100ps
module fsw_monitor (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // link
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    input  wire logic mosi_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_n_i,
    input  wire logic miso_line_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_hi_half;
        sclk_i [*8] ##1 !sclk_i;
    endsequence
    sequence s_lo_half;
        !sclk_i [*8];
    endsequence
    sequence s_bit_held;
        !cs_n_i && sclk_i && $past(sclk_i);
    endsequence

    a_sclk_high: assert property ($rose(sclk_i) |-> s_hi_half)
        else $error("link clock high half wrong");
    a_sclk_low: assert property ($fell(sclk_i) |-> s_lo_half)
        else $error("link clock low half wrong");
    a_cs_setup: assert property ($fell(cs_n_i) |-> s_lo_half)
        else $error("clock edge too soon after select");
    a_cs_gap: assert property ($rose(cs_n_i) |-> cs_n_i [*8])
        else $error("deselect gap too short");
    a_clk_idle: assert property (cs_n_i |-> !sclk_i)
        else $error("link clock moves while deselected");
    a_mosi_hold: assert property (s_bit_held |-> $stable(mosi_i))
        else $error("host data moved in clock high half");
    a_miso_hold: assert property ((s_bit_held ##0 !miso_oe_n_i) |-> $stable(miso_i))
        else $error("device data moved in clock high half");
    a_oe_release: assert property (cs_n_i [*6] |-> miso_oe_n_i)
        else $error("device drives line after deselect");
    // first bit leaves three clocks after the link clock falls
    a_oe_start: assert property ($fell(miso_oe_n_i) |-> !cs_n_i && !sclk_i
        && $past(sclk_i, 4) && miso_line_i == miso_i)
        else $error("device drives line outside a falling edge");
endmodule // fsw_monitor

// File: tb/testbench.sv
// self-checking bench: host and device joined over the link
`timescale 1ns/100ps
`include "fsw_defines.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module testbench;
    import fsw_pkg::*;
    localparam fsw_byte_t ID = 8'hC3; // arbitrary value
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic        pwr = 1'b0;
    logic [31:0] rdata;
    logic [31:0] rx;
    logic        busy;
    logic        op_start;
    fsw_byte_t   st_lo;
    fsw_byte_t   st_hi;
    fsw_byte_t   op_code;
    logic [23:0] op_addr;
    logic [1:0]  sreg_sel;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          starts = 0;

    fsw_link_if u_fsw_link_if ();
    fsw_host u_fsw_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .link(u_fsw_link_if));
    fsw_device #(.DEVICE_ID(ID)) u_fsw_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .power_cycle_i(pwr), .link(u_fsw_link_if), .busy_o(busy), .status_low_o(st_lo),
        .status_high_o(st_hi), .op_start_o(op_start), .op_code_o(op_code),
        .op_addr_o(op_addr), .sreg_sel_o(sreg_sel));
    fsw_monitor u_fsw_monitor (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(u_fsw_link_if.sclk),
        .cs_n_i(u_fsw_link_if.cs_n), .mosi_i(u_fsw_link_if.mosi), .miso_i(u_fsw_link_if.miso),
        .miso_oe_n_i(u_fsw_link_if.miso_oe_n), .miso_line_i(u_fsw_link_if.miso_line));

    // start pulse lasts one cycle, so count it where it stands
    always @(posedge clk_i)
        if (op_start === 1'b1)
            starts <= starts + 1;

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic results();
        $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_i);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    // one whole frame; tx bytes leave from the top of tx
    task automatic xfer(input logic [31:0] tx, input logic [2:0] nt, input logic [2:0] nr);
        logic [31:0] s;
        int i;
        wr(`FSW_REG_TXDATA, tx);
        wr(`FSW_REG_CTRL, {21'h0, nr, 5'h0, nt});
        for (i = 0; i < 2000; i++)
        begin
            rd(`FSW_REG_STATUS, s);
            if (s[0] === 1'b0)
                break;
        end
        if (i == 2000)
        begin
            error_cnt++;
            results();
        end
        rd(`FSW_REG_RXDATA, rx);
    endtask

    // self-timed cycle is 500 clocks; allow some margin
    task automatic wait_idle();
        int i;
        for (i = 0; i < 700 && busy !== 1'b0; i++)
            @(posedge clk_i);
        `CHK("busy end", 1'b0, busy)
        if (busy !== 1'b0)
            results();
    endtask

    task automatic power_cycle();
        @(posedge clk_i);
        pwr <= 1'b1;
        @(posedge clk_i);
        pwr <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic s_latch();
        xfer(32'h0600_0000, 3'd1, 3'd0);
        `CHK("latch set", 1'b1, st_lo[`FSW_ST_WPL])
        xfer(32'h0500_0000, 3'd1, 3'd2);
        `CHK("status repeat", 16'h0202, rx[15:0])
        xfer(32'h0400_0000, 3'd1, 3'd0);
        `CHK("latch clear", 1'b0, st_lo[`FSW_ST_WPL])
    endtask

    task automatic s_id();
        xfer(32'hAB00_0000, 3'd4, 3'd2);
        `CHK("id bytes", {ID, ID}, rx[15:0])
    endtask

    task automatic s_sreg();
        for (int k = 1; k <= 3; k++)
        begin
            xfer(32'h0600_0000, 3'd1, 3'd0);
            xfer({16'h4400, 4'(k), 12'h005}, 3'd4, 3'd0);
            `CHK("sreg select", 2'(k), sreg_sel)
            `CHK("sreg code", 8'h44, op_code)
            `CHK("sreg addr", {8'h00, 4'(k), 12'h005}, op_addr)
            `CHK("op starts", k, starts)
            `CHK("sreg busy", 1'b1, busy)
            wait_idle();
            `CHK("latch after op", 1'b0, st_lo[`FSW_ST_WPL])
        end
        xfer(32'h4400_1005, 3'd4, 3'd0);
        `CHK("no latch op", 1'b0, busy)
        `CHK("no latch start", 3, starts)
        xfer(32'h0600_0000, 3'd1, 3'd0);
        xfer(32'hC700_0000, 3'd1, 3'd0);
        `CHK("erase start", 4, starts)
        `CHK("erase code", 8'hC7, op_code)
        wait_idle();
        `CHK("latch after erase", 1'b0, st_lo[`FSW_ST_WPL])
    endtask

    task automatic s_vol();
        xfer(32'h5000_0000, 3'd1, 3'd0);
        `CHK("arm keeps latch", 1'b0, st_lo[`FSW_ST_WPL])
        xfer(32'h01A4_0200, 3'd3, 3'd0);
        `CHK("volatile busy", 1'b0, busy)
        `CHK("volatile low", 8'hA4, st_lo)
        `CHK("volatile high", 8'h02, st_hi)
        power_cycle();
        `CHK("reload low", 8'h00, st_lo)
        `CHK("reload high", 8'h00, st_hi)
        xfer(32'h5000_0000, 3'd1, 3'd0);
        xfer(32'h0400_0000, 3'd1, 3'd0);
        xfer(32'h01FF_FF00, 3'd3, 3'd0);
        `CHK("cancelled arm", 16'h0000, {st_hi, st_lo})
    endtask

    task automatic s_nv();
        xfer(32'h0600_0000, 3'd1, 3'd0);
        xfer(32'h01FF_FF00, 3'd3, 3'd0);
        `CHK("write busy", 1'b1, busy)
        xfer(32'h0500_0000, 3'd1, 3'd1);
        `CHK("read while busy", 8'hFF, rx[7:0])
        wait_idle();
        `CHK("nv low", 8'hFC, st_lo)
        `CHK("nv high", 8'h7F, st_hi)
        xfer(32'h3500_0000, 3'd1, 3'd1);
        `CHK("high read", 8'h7F, rx[7:0])
        power_cycle();
        `CHK("nv kept", 8'h7F, st_hi)
    endtask

    task automatic s_otp();
        xfer(32'h0600_0000, 3'd1, 3'd0);
        xfer(32'h0100_0000, 3'd2, 3'd0);
        wait_idle();
        `CHK("short write", 16'h3D00, {st_hi, st_lo})
        xfer(32'h5000_0000, 3'd1, 3'd0);
        xfer(32'h0100_0000, 3'd3, 3'd0);
        `CHK("volatile otp", 8'h39, st_hi)
        xfer(32'h0600_0000, 3'd1, 3'd0);
        xfer(32'h0100_0000, 3'd3, 3'd0);
        wait_idle();
        `CHK("locks kept", 8'h38, st_hi)
    endtask

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        s_latch();
        s_id();
        s_sreg();
        s_vol();
        s_nv();
        s_otp();
        results();
    end
endmodule // testbench
